// [rtl/blk_io_seq.sv]
// Block and automatic I/O transfer sequencer between memory and a peripheral
// Behaviour
// [R1] - Block in/out holds off all interrupt service until every word has moved
// [R2] - Block instruction second word is buffer base address minus one
// [R3] - Index register holds the positive count of words left to move
// [R4] - Block word address is base-minus-one plus current index value
// [R5] - Index decrements per word, so buffer goes highest address down to base
// [R6] - Index reaching zero ends the block instruction, next sequential instruction follows
// [R7] - Eight-bit select: upper five bits device, lower three bits function
// [R8] - Split form: device 0 to 1f, function 0 to 7
// [R9] - Block input moves one peripheral word to memory per true sense
// [R10] - Block output moves one memory word to peripheral per true sense
// [R11] - False sense makes the block instruction wait and retest, never ending it
// [R12] - Auto instructions leave accumulator and index register unchanged
// [R13] - Each auto execution bumps counter and pointer and moves one unit
// [R14] - Auto instruction is opcode, negative count, and start-minus-one pointer
// [R15] - Auto transfers step through the buffer in ascending address order
// [R16] - Auto counter and pointer increment before the unit is moved
// [R17] - In-line auto continues at P+3 on zero count, otherwise P+4
// [R18] - From an interrupt location a zero count raises end-of-block to peripheral
// [R19] - Peripheral answers true sense only when it can accept or supply a word
`timescale 1ns/1ps
`default_nettype none
module blk_io_seq
   import blk_io_pkg::*;
#(
   parameter int unsigned DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                srst,
   // Command from the instruction decoder
   input  wire logic                cmd_valid,
   input  wire cmd_s                cmd,
   input  wire logic                split_sel,    // Device and function given apart
   input  wire sel_s                cmd_sel,
   input  wire logic [WORD_W-1:0]   a_in,
   output logic                     cmd_ready,
   output logic                     done_valid,
   output done_s                    done,
   output logic [WORD_W-1:0]        a_out,
   output logic                     sel_error,
   output logic                     int_hold,
   // Memory port, one access at a time
   output logic                     mem_req,
   output logic                     mem_we,
   output logic                     mem_byte,
   output logic [ADDR_W-1:0]        mem_addr,
   output logic [WORD_W-1:0]        mem_wdata,
   input  wire logic                mem_ack,
   input  wire logic [WORD_W-1:0]   mem_rdata,
   // Peripheral I/O bus
   output logic                     sense_req,
   output logic [DEV_W-1:0]         io_dev,
   output logic [FN_W-1:0]          io_fn,
   input  wire logic                sense_true,
   input  wire logic [WORD_W-1:0]   per_rdata,
   output logic                     per_wr,
   output logic [WORD_W-1:0]        per_wdata,
   output logic                     per_rd,
   output logic                     eob_out
);
   initial begin
      if (DEPTH < 2) begin
         $error("blk_io_seq needs a buffer of at least two words");
      end
   end

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef enum logic [5:0] {
      ST_IDLE  = 6'b000001,
      ST_SENSE = 6'b000010,   // Block: test function, retest on false
      ST_MEMRD = 6'b000100,   // Memory read for output
      ST_MEMWR = 6'b001000,   // Memory write of input data
      ST_STEP  = 6'b010000,   // Block: index decrement and end test
      ST_DONE  = 6'b100000
   } st_e;

   st_e               st_q;
   op_e               op_q;
   cmd_s              cmd_q;
   logic [WORD_W-1:0] x_q;
   logic [WORD_W-1:0] cnt_q;
   logic [ADDR_W-1:0] ptr_q;
   logic [DEV_W-1:0]  dev_q;
   logic [FN_W-1:0]   fn_q;
   logic              is_block;
   logic              is_input;
   logic              is_byte;
   logic              sel_ok;
   logic [ADDR_W-1:0] cur_addr;

   // Input data path passes through the buffer before memory
   logic              fi_valid;
   logic              fi_ready;
   logic              fo_valid;
   logic              fo_ready;
   logic [WORD_W-1:0] fo_data;

   assign is_block = (op_q == block_input_op) || (op_q == block_output_op);
   assign is_input = (op_q == block_input_op) || (op_q == auto_input_word_op)
                     || (op_q == auto_input_byte_op);
   assign is_byte  = (op_q == auto_input_byte_op) || (op_q == auto_output_byte_op);
   // Split operands may only reach the printed limits
   assign sel_ok   = !split_sel || (cmd_sel.dev <= DEV_MAX && cmd_sel.fn <= FN_MAX); // [R8]
   // Block runs downward from base-1+X, auto upward from the pre-bumped pointer
   assign cur_addr = is_block ? cmd_q.base_m1 + x_q : ptr_q;                  // [R4] [R15]

   // ---------------------------------------------------------------
   // Input buffer
   // ---------------------------------------------------------------
   assign fi_valid = per_rd;
   assign fo_ready = (st_q == ST_MEMWR) && mem_req && mem_ack;

   io_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clock     (clock),
      .srst      (srst),
      .in_valid  (fi_valid),
      .in_ready  (fi_ready),
      .in_data   (per_rdata),
      .out_valid (fo_valid),
      .out_ready (fo_ready),
      .out_data  (fo_data)
   );

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   // Single process for the state so each transition is seen in one place
   always_ff @(posedge clock) begin
      if (srst) begin
         st_q <= ST_IDLE;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               if (cmd_valid && cmd_ready && sel_ok) begin
                  st_q <= (cmd.op == block_input_op || cmd.op == block_output_op)
                          ? ((cmd.count == '0) ? ST_DONE : ST_SENSE)
                          : ((cmd.op == auto_output_word_op || cmd.op == auto_output_byte_op)
                             ? ST_MEMRD : ST_MEMWR);
               end
            end
            ST_SENSE: begin
               // A false answer leaves us here to test again
               if (sense_req && sense_true) begin                             // [R11]
                  st_q <= is_input ? ST_MEMWR : ST_MEMRD;
               end
            end
            ST_MEMRD: begin
               if (mem_req && mem_ack) begin
                  st_q <= is_block ? ST_STEP : ST_DONE;
               end
            end
            ST_MEMWR: begin
               if (fo_ready) begin
                  st_q <= is_block ? ST_STEP : ST_DONE;
               end
            end
            ST_STEP: begin
               st_q <= (x_q == ONE) ? ST_DONE : ST_SENSE;                     // [R6]
            end
            ST_DONE: begin
               st_q <= ST_IDLE;
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Command capture; select split into device and function fields
   always_ff @(posedge clock) begin
      if (srst) begin
         op_q  <= block_input_op;
         cmd_q <= '0;
         dev_q <= '0;
         fn_q  <= '0;
      end else if (st_q == ST_IDLE && cmd_valid) begin
         op_q  <= cmd.op;
         cmd_q <= cmd;                                                        // [R2] [R14]
         dev_q <= split_sel ? cmd_sel.dev : cmd.devfn[DEV_LSB +: DEV_W];      // [R7]
         fn_q  <= split_sel ? cmd_sel.fn : cmd.devfn[FN_W-1:0];               // [R7]
      end
   end

   // Index register for block; auto never writes it
   always_ff @(posedge clock) begin
      if (srst) begin
         x_q <= '0;
      end else if (st_q == ST_IDLE && cmd_valid
                   && (cmd.op == block_input_op || cmd.op == block_output_op)) begin
         x_q <= cmd.count;                                                    // [R3] [R12]
      end else if (st_q == ST_STEP) begin
         x_q <= x_q - ONE;                                                    // [R5]
      end
   end

   // Auto counter and pointer bumped at acceptance, ahead of the transfer
   always_ff @(posedge clock) begin
      if (srst) begin
         cnt_q <= '0;
         ptr_q <= '0;
      end else if (st_q == ST_IDLE && cmd_valid) begin
         cnt_q <= cmd.count + ONE;                                            // [R13] [R16]
         ptr_q <= cmd.base_m1 + ONE;                                          // [R13] [R16]
      end
   end

   // ---------------------------------------------------------------
   // Handshake outputs, all registered
   // ---------------------------------------------------------------
   // Idle readiness; interrupts held for the whole block instruction
   always_ff @(posedge clock) begin
      if (srst) begin
         cmd_ready <= 1'b0;
         int_hold  <= 1'b0;
         sel_error <= 1'b0;
      end else begin
         cmd_ready <= (st_q == ST_IDLE) && !(cmd_valid && cmd_ready);
         sel_error <= (st_q == ST_IDLE) && cmd_valid && cmd_ready && !sel_ok;
         if (st_q == ST_IDLE && cmd_valid && cmd_ready && sel_ok) begin
            int_hold <= (cmd.op == block_input_op) || (cmd.op == block_output_op); // [R1]
         end else if (st_q == ST_DONE) begin
            int_hold <= 1'b0;                                                 // [R1]
         end
      end
   end

   // Sense test and peripheral strobes; a read only when the buffer has room
   always_ff @(posedge clock) begin
      if (srst) begin
         sense_req <= 1'b0;
         per_rd    <= 1'b0;
         per_wr    <= 1'b0;
         per_wdata <= '0;
         io_dev    <= '0;
         io_fn     <= '0;
      end else begin
         io_dev    <= dev_q;
         io_fn     <= fn_q;
         sense_req <= (st_q == ST_SENSE) && !(sense_req && sense_true) && fi_ready; // [R11]
         // Block input takes its word on the true sense, auto input unconditionally
         per_rd    <= ((st_q == ST_SENSE) && is_input && sense_req && sense_true) // [R9]
                      || (st_q == ST_IDLE && cmd_valid && cmd_ready && sel_ok
                          && (cmd.op == auto_input_word_op || cmd.op == auto_input_byte_op));
         per_wr    <= (st_q == ST_MEMRD) && mem_req && mem_ack;               // [R10]
         if (st_q == ST_MEMRD && mem_req && mem_ack) begin
            per_wdata <= is_byte ? {{BYTE_W{1'b0}}, mem_rdata[BYTE_W-1:0]} : mem_rdata;
         end
      end
   end

   // Memory port: one request held until acknowledged
   always_ff @(posedge clock) begin
      if (srst) begin
         mem_req   <= 1'b0;
         mem_we    <= 1'b0;
         mem_byte  <= 1'b0;
         mem_addr  <= '0;
         mem_wdata <= '0;
      end else begin
         if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
         end else if ((st_q == ST_MEMRD) || (st_q == ST_MEMWR && fo_valid)) begin
            mem_req <= 1'b1;
         end
         mem_we    <= (st_q == ST_MEMWR);
         mem_byte  <= is_byte;
         mem_addr  <= cur_addr;                                               // [R4] [R15]
         mem_wdata <= is_byte ? {{BYTE_W{1'b0}}, fo_data[BYTE_W-1:0]} : fo_data;
      end
   end

   // Completion report: next P, final X, count, pointer and end-of-block
   always_ff @(posedge clock) begin
      if (srst) begin
         done_valid <= 1'b0;
         done       <= '0;
         eob_out    <= 1'b0;
         a_out      <= '0;
      end else begin
         done_valid <= (st_q == ST_DONE);
         eob_out    <= 1'b0;
         if (st_q == ST_DONE) begin
            a_out          <= a_in;                                           // [R12]
            done.x_final   <= x_q;                                            // [R12]
            done.count_final <= is_block ? x_q : cnt_q;
            done.ptr_final <= is_block ? cmd_q.base_m1 : ptr_q;
            done.eob       <= !is_block && cnt_q == '0;
            if (is_block) begin
               done.pc_next <= cmd_q.pc + 16'h0002;                           // [R6]
            end else if (cmd_q.from_int) begin
               done.pc_next <= cmd_q.pc;  // Caller resumes main line
               eob_out      <= (cnt_q == '0);                                 // [R18]
            end else begin
               done.pc_next <= cmd_q.pc + ((cnt_q == '0) ? EOB_EXIT_OFS : NEXT_INST_OFS); // [R17]
            end
         end
      end
   end
endmodule : blk_io_seq
`default_nettype wire

// [rtl/blk_io_pkg.sv]
// Package: opcodes, field layouts, widths and carriers for the block and auto I/O sequencer
package blk_io_pkg;

   // ---------------------------------------------------------------
   // Widths and field layout
   // ---------------------------------------------------------------
   localparam int unsigned WORD_W     = 16;
   localparam int unsigned ADDR_W     = 16;
   localparam int unsigned DEVFN_W    = 8;
   localparam int unsigned DEV_W      = 5;
   localparam int unsigned FN_W       = 3;
   localparam int unsigned DEV_LSB    = 3;
   localparam int unsigned BYTE_W     = 8;
   localparam int unsigned FIFO_DEPTH = 16;

   // Largest legal split device and function values
   localparam logic [DEV_W-1:0] DEV_MAX = 5'h1f;
   localparam logic [FN_W-1:0]  FN_MAX  = 3'h7;

   // ---------------------------------------------------------------
   // Instruction classes
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      block_input_op       = 3'h0,
      block_output_op      = 3'h1,
      auto_input_word_op   = 3'h2,
      auto_input_byte_op   = 3'h3,
      auto_output_word_op  = 3'h4,
      auto_output_byte_op  = 3'h5
   } op_e;

   // Program counter advance after an in-line auto instruction, and the unit step ONE
   localparam logic [ADDR_W-1:0] EOB_EXIT_OFS  = 16'h0003;
   localparam logic [ADDR_W-1:0] NEXT_INST_OFS = 16'h0004;
   localparam logic [ADDR_W-1:0] ONE           = 16'h0001;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      op_e                 op;
      logic [DEVFN_W-1:0]  devfn;      // Upper 5 device, lower 3 function
      logic [ADDR_W-1:0]   base_m1;    // Second word, or auto pointer
      logic [WORD_W-1:0]   count;      // X for block, negative count for auto
      logic [ADDR_W-1:0]   pc;         // Address of the opcode word
      logic                from_int;   // Executed at an interrupt location
   } cmd_s;

   typedef struct packed {
      logic [DEV_W-1:0] dev;
      logic [FN_W-1:0]  fn;
   } sel_s;

   typedef struct packed {
      logic [ADDR_W-1:0] pc_next;
      logic [WORD_W-1:0] x_final;
      logic [WORD_W-1:0] count_final;
      logic [ADDR_W-1:0] ptr_final;
      logic              eob;
   } done_s;

endpackage : blk_io_pkg

// [rtl/io_fifo.sv]
// Synchronous valid/ready FIFO held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module io_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             srst,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
         $error("io_fifo depth must be a power of two, at least 2");
      end
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_q;
   logic [PW-1:0]    rd_q;
   logic [PW:0]      cnt_q;
   logic             push;
   logic             pop;

   // ---------------------------------------------------------------
   // Flags come from the occupancy count so full and empty are exact
   // ---------------------------------------------------------------
   assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Storage write
   always_ff @(posedge clock) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // Pointers and count
   always_ff @(posedge clock) begin
      if (srst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + PW'(1);
         end
         if (pop) begin
            rd_q <= rd_q + PW'(1);
         end
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule : io_fifo
`default_nettype wire

// [sim/blk_io_chk.sv]
// Checker: assertions on the I/O sequencer
`timescale 1ns/1ps
`default_nettype none
module blk_io_chk
   import blk_io_pkg::*;
(
   // Clock and reset
   input wire logic              clock,
   input wire logic              srst,
   // Command side
   input wire logic              cmd_valid,
   input wire cmd_s              cmd,
   input wire logic              split_sel,
   input wire sel_s              cmd_sel,
   input wire logic              cmd_ready,
   input wire logic              done_valid,
   input wire logic              int_hold,
   // Memory and peripheral side
   input wire logic              mem_req,
   input wire logic              mem_ack,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic              mem_we,
   input wire logic              sense_req,
   input wire logic              sense_true,
   input wire logic [DEV_W-1:0]  io_dev,
   input wire logic [FN_W-1:0]   io_fn,
   input wire logic              per_rd,
   input wire logic              per_wr,
   input wire logic [WORD_W-1:0] per_wdata,
   input wire logic              eob_out
);
   logic [DEV_W-1:0] dev_q;
   logic [FN_W-1:0]  fn_q;
   logic             int_q;
   logic             byte_q;
   wire logic        take = cmd_valid && cmd_ready;
   wire logic        blk  = cmd.op inside {block_input_op, block_output_op};

   // Latch select and mode at take
   always_ff @(posedge clock) begin
      if (take) begin
         dev_q  <= split_sel ? cmd_sel.dev : cmd.devfn[DEVFN_W-1:DEV_LSB];
         fn_q   <= split_sel ? cmd_sel.fn : cmd.devfn[FN_W-1:0];
         int_q  <= cmd.from_int;
         byte_q <= cmd.op inside {auto_input_byte_op, auto_output_byte_op};
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   a_ready_drop: assert property (take |=> !cmd_ready)
      else $error("ready stayed high after take");
   a_done_pulse: assert property (done_valid |=> !done_valid)
      else $error("done too long");
   a_mem_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
      else $error("memory request changed");
   a_sense_wait: assert property (sense_req && !sense_true |=> sense_req && $stable(io_dev))
      else $error("false sense ended the test");
   a_sel_decode: assert property (sense_req |-> io_dev == dev_q && io_fn == fn_q)
      else $error("select wrong");
   a_hold_block: assert property (take && blk && cmd.count != 16'h0000 |-> ##[1:2] int_hold)
      else $error("interrupts not held");
   a_hold_end: assert property ($fell(int_hold) |-> (done_valid || $past(done_valid)) or (##1 done_valid))
      else $error("hold dropped early");
   a_eob_cause: assert property (eob_out |-> int_q)
      else $error("end of block in line");
   a_byte_upper: assert property (per_wr && byte_q |-> per_wdata[15:8] == 8'h00)
      else $error("byte upper half set");
   a_io_pulse: assert property (per_wr || per_rd |=> !per_wr && !per_rd)
      else $error("strobe too long");
endmodule : blk_io_chk

bind blk_io_seq blk_io_chk chk (.*);
`default_nettype wire

// [sim/per_model.sv]
// Peripheral model: paced sense, read data, write log
`timescale 1ns/1ps
`default_nettype none
module per_model
   import blk_io_pkg::*;
(
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              srst,
   // False answers before a true one
   input  wire logic [3:0]        lag,
   // Peripheral I/O bus
   input  wire logic              sense_req,
   input  wire logic              per_rd,
   input  wire logic              per_wr,
   input  wire logic [WORD_W-1:0] per_wdata,
   input  wire logic              eob_out,
   output logic                   sense_true,
   output logic [WORD_W-1:0]      per_rdata
);
   logic [3:0]        wait_q;
   logic [WORD_W-1:0] rd_n;
   logic [WORD_W-1:0] wr_log [0:15];
   int                wr_n;
   int                eob_n;

   // True only once the device is ready to move a word
   assign sense_true = sense_req && (wait_q == 4'h0);
   // Inverse when not strobed
   assign per_rdata = per_rd ? 16'ha500 + rd_n : ~(16'ha500 + rd_n);

   // Pace, data and log
   always @(posedge clock) begin
      if (srst) begin
         wait_q <= lag;
         rd_n   <= 16'h0000;
         wr_n   <= 0;
         eob_n  <= 0;
      end else begin
         wait_q <= !sense_req ? lag : (wait_q != 4'h0 ? wait_q - 4'h1 : wait_q);
         if (per_rd) rd_n <= rd_n + 16'h0001;
         if (per_wr) begin
            wr_log[wr_n % 16] <= per_wdata;
            wr_n              <= wr_n + 1;
         end
         if (eob_out) eob_n <= eob_n + 1;
      end
   end
endmodule : per_model
`default_nettype wire

// [sim/blk_io_seq_tb_top.sv]
// Testbench: block and auto I/O scenarios
`timescale 1ns/1ps
`default_nettype none
module blk_io_seq_tb_top;
   import blk_io_pkg::*;
   logic clock = 1'b0, srst = 1'b1, cmd_valid = 1'b0, split_sel = 1'b0, mem_ack = 1'b0;
   cmd_s cmd = '0;
   sel_s cmd_sel = '0;
   done_s done, res;
   logic [WORD_W-1:0] a_in = 16'h1234, a_out, mem_wdata, per_rdata, per_wdata;
   logic [ADDR_W-1:0] mem_addr;
   logic [DEV_W-1:0]  io_dev;
   logic [FN_W-1:0]   io_fn;
   logic [3:0]        lag = 4'h0;
   logic cmd_ready, done_valid, sel_error, int_hold, mem_req, mem_we, mem_byte, sense_req;
   logic sense_true, per_wr, per_rd, eob_out;
   logic [WORD_W-1:0] mem [0:255];
   int err_total = 0, cmp_count = 0, hold_n = 0;

   blk_io_seq uut (.clock(clock), .srst(srst), .cmd_valid(cmd_valid), .cmd(cmd),
      .split_sel(split_sel), .cmd_sel(cmd_sel), .a_in(a_in), .cmd_ready(cmd_ready),
      .done_valid(done_valid), .done(done), .a_out(a_out), .sel_error(sel_error),
      .int_hold(int_hold), .mem_req(mem_req), .mem_we(mem_we), .mem_byte(mem_byte),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
      .mem_rdata(mem_ack ? mem[mem_addr[7:0]] : ~mem[mem_addr[7:0]]),
      .sense_req(sense_req), .io_dev(io_dev), .io_fn(io_fn), .sense_true(sense_true),
      .per_rdata(per_rdata), .per_wr(per_wr), .per_wdata(per_wdata), .per_rd(per_rd),
      .eob_out(eob_out));
   per_model pm (.clock(clock), .srst(srst), .lag(lag), .sense_req(sense_req), .per_rd(per_rd),
      .per_wr(per_wr), .per_wdata(per_wdata), .eob_out(eob_out), .sense_true(sense_true),
      .per_rdata(per_rdata));

   always #10 clock = ~clock;
   // Memory acks one cycle after each request
   always @(posedge clock) begin
      mem_ack <= mem_req && !mem_ack;
      if (mem_req && !mem_ack && mem_we) mem[mem_addr[7:0]] <= mem_wdata;
      if (int_hold === 1'b1) hold_n++;
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask : chk

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report

   // Offer one command, wait for completion
   task automatic run(input op_e op, input logic [7:0] df, input logic [15:0] base, cnt, pc,
                      input logic fi);
      int n;
      n = 0;
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd <= '{op: op, devfn: df, base_m1: base, count: cnt, pc: pc, from_int: fi};
      do begin @(negedge clock); n++; end while (cmd_ready !== 1'b1 && n < 2000);
      @(posedge clock);
      cmd_valid <= 1'b0;
      do begin @(negedge clock); n++; end while (done_valid !== 1'b1 && n < 4000);
      if (n >= 4000) begin
         err_total++;
         $display("Error at %0t: no completion", $time);
         final_report();
      end else res = done;
   endtask : run

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_block_out();
      int n0, h0;
      n0 = pm.wr_n;
      h0 = hold_n;
      for (int i = 1; i <= 3; i++) mem[8'h40 + i] = 16'h1000 + 16'(i);
      lag <= 4'h3;
      split_sel <= 1'b1;
      cmd_sel <= '{dev: DEV_MAX, fn: FN_MAX};
      run(block_output_op, 8'h00, 16'h0040, 16'h0003, 16'h0100, 1'b0);
      chk(pm.wr_n - n0 == 3, "block out word count");
      for (int i = 0; i < 3; i++) chk(pm.wr_log[(n0 + i) % 16] === 16'h1003 - 16'(i), "out order");
      chk(res.x_final === 16'h0000 && res.pc_next === 16'h0102, "block out end");
      chk(hold_n > h0, "interrupts not held");
      $display("block out test done");
   endtask : t_block_out

   task automatic t_block_in();
      logic [15:0] r0;
      r0 = pm.rd_n;
      mem[8'h50] = 16'h5555;
      lag <= 4'h0;
      split_sel <= 1'b0;
      run(block_input_op, 8'hff, 16'h0050, 16'h0002, 16'h0200, 1'b0);
      chk(mem[8'h52] === 16'ha500 + r0, "first input word place");
      chk(mem[8'h51] === 16'ha501 + r0, "second input word place");
      chk(mem[8'h50] === 16'h5555 && res.pc_next === 16'h0202, "below base touched");
      $display("block in test done");
   endtask : t_block_in

   task automatic t_auto_inline();
      op_e ops [4] = '{auto_input_word_op, auto_input_byte_op, auto_output_word_op,
                       auto_output_byte_op};
      logic [15:0] cnt, r0;
      for (int i = 0; i < 8; i++) begin
         cnt = (i < 4) ? 16'hfffe : 16'hffff;
         r0 = pm.rd_n;
         mem[8'h60 + i] = 16'h2000 + 16'(i);
         run(ops[i % 4], 8'h21, 16'h005f + 16'(i), cnt, 16'h0300, 1'b0);
         chk(res.count_final === cnt + ONE, "auto count");
         chk(res.ptr_final === 16'h0060 + 16'(i), "auto pointer");
         chk(res.pc_next === 16'h0300 + ((i < 4) ? NEXT_INST_OFS : EOB_EXIT_OFS), "exit");
         chk(a_out === a_in && res.x_final === 16'h0000, "A or X changed");
         if (i % 4 == 0) chk(mem[8'h60 + i] === 16'ha500 + r0, "auto input word");
         if (i % 4 == 2) chk(pm.wr_log[(pm.wr_n + 15) % 16] === 16'h2000 + 16'(i), "auto out");
      end
      $display("auto in-line test done");
   endtask : t_auto_inline

   task automatic t_auto_int();
      int e0;
      e0 = pm.eob_n;
      run(auto_output_word_op, 8'h22, 16'h0070, 16'hfffe, 16'h0010, 1'b1);
      repeat (2) @(negedge clock);
      chk(pm.eob_n === e0, "early end of block");
      run(auto_output_word_op, 8'h22, 16'h0071, 16'hffff, 16'h0010, 1'b1);
      repeat (2) @(negedge clock);
      chk(pm.eob_n === e0 + 1 && res.pc_next === 16'h0010, "no end of block");
      $display("auto interrupt test done");
   endtask : t_auto_int

   task automatic t_fifo();
      logic [15:0] r0;
      r0 = pm.rd_n;
      mem[8'h80] = 16'h0000;
      lag <= 4'h2;
      run(block_input_op, 8'h19, 16'h0080, 16'h0004, 16'h0400, 1'b0);
      chk(res.pc_next === 16'h0402, "buffered input end");
      for (int j = 0; j < 4; j++) chk(mem[8'h84 - j] === 16'ha500 + r0 + 16'(j), "order");
      chk(mem[8'h80] === 16'h0000 && int_hold === 1'b0, "base or hold");
      $display("buffered input test done");
   endtask : t_fifo

   // Main sequence
   initial begin
      repeat (6) @(posedge clock);
      srst <= 1'b0;
      t_block_out();
      t_block_in();
      t_auto_inline();
      t_auto_int();
      t_fifo();
      final_report();
   end
endmodule : blk_io_seq_tb_top
`default_nettype wire
